//--- logic/clk_chain_pkg.sv
package clk_chain_pkg;
  // ==========================================
  // Oscillator divider
  localparam int OSC_RATIO = 4;
  localparam logic [1:0] PHASE_RESET = 2'h0;
  localparam logic [1:0] PHASE_LAST = 2'h3;
  localparam logic [1:0] PHASE_STROBE = 2'h1;
  localparam int CLK_HZ = 50000000;
  // ==========================================
  // Prescaler and main counter
  localparam int COUNT_W = 16;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [1:0] PRESC_RESET = 2'h0;
  localparam int PRESC_W = 4;
  localparam logic [3:0] PRESC_CHAIN_RESET = 4'h0;
  localparam logic [1:0] PRESC_DIV1 = 2'h0;
  localparam logic [1:0] PRESC_DIV4 = 2'h1;
  localparam logic [1:0] PRESC_DIV8 = 2'h2;
  localparam logic [1:0] PRESC_DIV16 = 2'h3;
  // ==========================================
  // Compensated taps, log2 of bus-clock division
  localparam int TAP_PULSE_LOG2 = 6;
  localparam int TAP_PERIODIC_LOG2 = 13;
  localparam int TAP_WATCHDOG_LOG2 = 15;
  localparam int TAP_COUNT = 3;
  // ==========================================
  // Baud chain and start-up delay
  localparam int BAUD_W = 13;
  localparam logic [12:0] BAUD_RESET = 13'h0000;
  localparam int STARTUP_BUS_CYCLES = 4064;
  localparam logic [12:0] DELAY_RESET = 13'h0000;
  // ==========================================
  // Run states, Gray along the cycle
  typedef enum logic [1:0]
  {
    ST_STARTUP = 2'b00,
    ST_RESUME = 2'b01,
    ST_RUN = 2'b11,
    ST_STOPPED = 2'b10
  } run_state_e;

  // Shift of the prescale factor
  function automatic int presc_shift(input logic [1:0] sel);
    int s;
    s = 0;
    unique case (sel)
      PRESC_DIV1: s = 0;
      PRESC_DIV4: s = 2;
      PRESC_DIV8: s = 3;
      PRESC_DIV16: s = 4;
    endcase
    return s;
  endfunction
endpackage

//--- logic/free_run_counter.sv
`timescale 1ns/1ps
module free_run_counter
  import clk_chain_pkg::*;
#(
  parameter int WIDTH = COUNT_W
)
(
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  // Count enable
  input wire logic tick_in,
  // Count value
  output logic [WIDTH-1:0] count_out
);
  logic [WIDTH-1:0] next_count;

  // ==========================================
  // Wrapping up-counter
  always_comb
  begin
    next_count = count_out;
    if (tick_in)
    begin
      next_count = count_out + WIDTH'(1);
    end
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      count_out <= WIDTH'(COUNT_RESET);
    end
    else
    begin
      count_out <= next_count;
    end
  end

  // ==========================================
  // Checks
  count_step_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
      tick_in |=> count_out == $past(count_out) + WIDTH'(1))
    else $error("counter did not step by one");
  count_hold_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
      !tick_in |=> $stable(count_out))
    else $error("counter moved without a tick");
endmodule

//--- logic/timer_clock_divider_chain.sv
`timescale 1ns/1ps
module timer_clock_divider_chain
  import clk_chain_pkg::*;
#(
  parameter int STARTUP_CYCLES = STARTUP_BUS_CYCLES,
  parameter int TAP_LOG2 [TAP_COUNT] = '{TAP_PULSE_LOG2, TAP_PERIODIC_LOG2, TAP_WATCHDOG_LOG2}
)
(
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  // Mode and power control
  input wire logic test_mode_in,
  input wire logic stop_req_in,
  input wire logic wake_in,
  input wire logic baud_clear_in,
  // Prescale select write
  input wire logic presc_wr_in,
  input wire logic [1:0] presc_sel_in,
  // Clock outputs
  output logic phase_two_out,
  output logic bus_clk_out,
  output logic address_latch_strobe_out,
  output logic run_out,
  // Timer chain
  output logic [COUNT_W-1:0] timer_count_out,
  output logic [1:0] prescale_sel_out,
  output logic write_window_out,
  output logic pulse_tap_out,
  output logic periodic_tap_out,
  output logic watchdog_tap_out,
  output logic [BAUD_W-1:0] baud_count_out
);
  run_state_e state, next_state;
  logic [1:0] phase, next_phase;
  logic [PRESC_W-1:0] presc_chain, next_presc_chain;
  logic [BAUD_W-1:0] delay, next_delay;
  logic [BAUD_W-1:0] next_baud;
  logic [1:0] next_prescale;
  logic locked, next_locked;
  logic next_window;
  logic next_phase_two, next_bus_clk, next_strobe, next_run;
  logic [TAP_COUNT-1:0] tap_hit, taps;
  logic clk_on, e_on, osc_tick, bus_tick, timer_tick, accept;
  logic [PRESC_W-1:0] pmask;

  function automatic logic chain_hit(input logic [COUNT_W-1:0] chain, input int bits);
    logic [COUNT_W-1:0] mask;
    mask = COUNT_W'((32'h1 << bits) - 32'h1);
    return (chain & mask) == mask;
  endfunction

  // ==========================================
  // Oscillator divider and gating
  assign osc_tick = (phase == PHASE_LAST);
  assign clk_on = (state == ST_RESUME) || (state == ST_RUN);
  assign e_on = (state == ST_RUN);
  assign bus_tick = clk_on && osc_tick;

  // ==========================================
  // Prescaler
  assign pmask = PRESC_W'((32'h1 << presc_shift(prescale_sel_out)) - 32'h1);
  assign timer_tick = bus_tick && ((presc_chain & pmask) == pmask);

  // ==========================================
  // Compensated taps off the main counter
  genvar gi;
  generate
    for (gi = 0; gi < TAP_COUNT; gi++)
    begin : g_tap
      assign tap_hit[gi] = timer_tick &&
        chain_hit(timer_count_out, TAP_LOG2[gi] - presc_shift(prescale_sel_out));
    end
  endgenerate

  assign accept = presc_wr_in && (test_mode_in || (write_window_out && !locked));

  // ==========================================
  // Next-state logic
  always_comb
  begin
    next_phase = phase + 2'h1;
    next_presc_chain = presc_chain;
    next_state = state;
    next_delay = delay;
    next_baud = baud_count_out;
    next_prescale = prescale_sel_out;
    next_locked = locked;
    next_window = write_window_out;
    if (osc_tick)
    begin
      next_baud = baud_count_out + BAUD_W'(1);
    end
    if (test_mode_in && baud_clear_in)
    begin
      next_baud = BAUD_RESET;
    end
    if (bus_tick)
    begin
      next_presc_chain = presc_chain + PRESC_W'(1);
    end
    if (accept)
    begin
      next_prescale = presc_sel_in;
      next_locked = locked || !test_mode_in;
    end
    if (tap_hit[0])
    begin
      next_window = 1'b0;
    end
    unique case (state)
      ST_STARTUP:
      begin
        if (osc_tick)
        begin
          next_delay = delay + BAUD_W'(1);
          if (int'(delay) >= STARTUP_CYCLES - 1)
          begin
            next_state = ST_RESUME;
            next_delay = DELAY_RESET;
          end
        end
      end
      ST_RESUME:
      begin
        if (osc_tick)
        begin
          next_state = ST_RUN;
        end
      end
      ST_RUN:
      begin
        if (stop_req_in && osc_tick)
        begin
          next_state = ST_STOPPED;
        end
      end
      ST_STOPPED:
      begin
        if (wake_in)
        begin
          next_state = ST_STARTUP;
        end
      end
    endcase
    next_phase_two = clk_on && next_phase[1];
    next_bus_clk = e_on && ((next_phase == PHASE_LAST) || (next_phase == PHASE_RESET));
    next_strobe = e_on && (next_phase == PHASE_STROBE);
    next_run = (next_state == ST_RUN);
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      state <= ST_STARTUP;
      phase <= PHASE_RESET;
      presc_chain <= PRESC_CHAIN_RESET;
      delay <= DELAY_RESET;
      baud_count_out <= BAUD_RESET;
      prescale_sel_out <= PRESC_RESET;
      locked <= 1'b0;
      write_window_out <= 1'b1;
      taps <= '0;
      phase_two_out <= 1'b0;
      bus_clk_out <= 1'b0;
      address_latch_strobe_out <= 1'b0;
      run_out <= 1'b0;
    end
    else
    begin
      state <= next_state;
      phase <= next_phase;
      presc_chain <= next_presc_chain;
      delay <= next_delay;
      baud_count_out <= next_baud;
      prescale_sel_out <= next_prescale;
      locked <= next_locked;
      write_window_out <= next_window;
      taps <= tap_hit;
      phase_two_out <= next_phase_two;
      bus_clk_out <= next_bus_clk;
      address_latch_strobe_out <= next_strobe;
      run_out <= next_run;
    end
  end

  assign pulse_tap_out = taps[0];
  assign periodic_tap_out = taps[1];
  assign watchdog_tap_out = taps[2];

  // ==========================================
  // Main counter
  free_run_counter #(
    .WIDTH(COUNT_W)
  ) u_counter (
    .sys_clk_in(sys_clk_in),
    .nrst_in(nrst_in),
    .tick_in(timer_tick),
    .count_out(timer_count_out)
  );

  // ==========================================
  // Checks
  logic [7:0] gap;
  logic gap_seen;
  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      gap <= 8'h00;
      gap_seen <= 1'b0;
    end
    else if (accept)
    begin
      gap_seen <= 1'b0;
    end
    else if (tap_hit[0])
    begin
      gap <= 8'h00;
      gap_seen <= 1'b1;
    end
    else if (bus_tick)
    begin
      gap <= gap + 8'h01;
    end
  end

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!nrst_in);

  bus_lag_a: assert property (e_on && $past(e_on) |-> bus_clk_out == $past(phase_two_out))
    else $error("bus clock not a quarter behind phase two");
  e_after_int_a: assert property ($rose(e_on) |-> $past(clk_on, 4))
    else $error("bus clock restarted before internal clocks");
  startup_hold_a: assert property ($rose(state == ST_RESUME) |-> $past(state == ST_STARTUP, 16))
    else $error("start-up delay cut short");
  startup_gate_a: assert property (state == ST_STARTUP |-> ##1 !phase_two_out)
    else $error("phase two running during start-up");
  fast_rate_a: assert property (prescale_sel_out == PRESC_DIV1 && bus_tick
      |=> timer_count_out == $past(timer_count_out) + 16'h0001)
    else $error("divide-by-1 missed a bus cycle");
  slow_rate_a: assert property (prescale_sel_out == PRESC_DIV16 && timer_tick
      && !accept |=> (!timer_tick)[*8])
    else $error("divide-by-16 counted too soon");
  count_wrap_a: assert property (timer_tick && timer_count_out == 16'hffff
      |=> timer_count_out == 16'h0000)
    else $error("counter did not wrap to zero");
  window_only_a: assert property (presc_wr_in && !test_mode_in && !write_window_out
      |=> $stable(prescale_sel_out))
    else $error("protected write outside window");
  rate_locked_a: assert property (!test_mode_in && locked && !$past(accept)
      |-> $stable(prescale_sel_out))
    else $error("prescale changed after lock");
  pulse_tap_a: assert property (tap_hit[0] && gap_seen |-> gap == 8'h3f)
    else $error("pulse tap not every 64 bus cycles");
  baud_free_a: assert property (!test_mode_in && osc_tick
      |=> baud_count_out == $past(baud_count_out) + 13'h0001)
    else $error("baud chain disturbed");

  presc_set_c: cover property (accept ##1 locked);
  stop_exit_c: cover property (state == ST_STOPPED ##1 state == ST_STARTUP);
  pulse_tap_c: cover property (tap_hit[0] && gap_seen);
  wrap_c: cover property (timer_tick && timer_count_out == 16'hffff);
endmodule

//--- verification/tap_consumer.sv
`timescale 1ns/1ps
// ==========================================
// Far-side timer users, counting tap events
module tap_consumer
(
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  // Tap pulses
  input wire logic pulse_tap_in,
  input wire logic periodic_tap_in,
  input wire logic watchdog_tap_in,
  // Event counts
  output logic [7:0] pulse_count_out,
  output logic [7:0] periodic_count_out,
  output logic [7:0] watchdog_count_out
);
  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      pulse_count_out <= 8'h00;
      periodic_count_out <= 8'h00;
      watchdog_count_out <= 8'h00;
    end
    else
    begin
      pulse_count_out <= pulse_count_out + 8'(pulse_tap_in);
      periodic_count_out <= periodic_count_out + 8'(periodic_tap_in);
      watchdog_count_out <= watchdog_count_out + 8'(watchdog_tap_in);
    end
  end
endmodule

//--- verification/test_timer_clock_divider_chain.sv
`timescale 1ns/1ps
module test_timer_clock_divider_chain;
  import clk_chain_pkg::*;
  // ==========================================
  // Signals
  logic sys_clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic test_mode_in = 1'b0;
  logic stop_req_in = 1'b0;
  logic wake_in = 1'b0;
  logic baud_clear_in = 1'b0;
  logic presc_wr_in = 1'b0;
  logic [1:0] presc_sel_in = 2'h0;
  logic pt, bc, als, run, win, tp, tr, tw;
  logic [15:0] cnt;
  logic [1:0] sel;
  logic [12:0] baud;
  logic [7:0] np, nr, nw;
  int mismatches = 0;
  int checked = 0;
  int cycles = 0;
  always #10 sys_clk_in = ~sys_clk_in;
  // ==========================================
  // Design and far side
  timer_clock_divider_chain #(.STARTUP_CYCLES(8), .TAP_LOG2('{6, 8, 9})) DUT
  (
    .sys_clk_in(sys_clk_in),
    .nrst_in(nrst_in),
    .test_mode_in(test_mode_in),
    .stop_req_in(stop_req_in),
    .wake_in(wake_in),
    .baud_clear_in(baud_clear_in),
    .presc_wr_in(presc_wr_in),
    .presc_sel_in(presc_sel_in),
    .phase_two_out(pt),
    .bus_clk_out(bc),
    .address_latch_strobe_out(als),
    .run_out(run),
    .timer_count_out(cnt),
    .prescale_sel_out(sel),
    .write_window_out(win),
    .pulse_tap_out(tp),
    .periodic_tap_out(tr),
    .watchdog_tap_out(tw),
    .baud_count_out(baud)
  );
  tap_consumer model
  (
    .sys_clk_in(sys_clk_in),
    .nrst_in(nrst_in),
    .pulse_tap_in(tp),
    .periodic_tap_in(tr),
    .watchdog_tap_in(tw),
    .pulse_count_out(np),
    .periodic_count_out(nr),
    .watchdog_count_out(nw)
  );
  // ==========================================
  // Tasks
  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected %s: expected %0h, seen %0h", name, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk_in);
  endtask
  function automatic logic [15:0] rate(input logic [1:0] code, input int ticks);
    return 16'(code == 2'h0 ? ticks : ticks >> (int'(code) + 1));
  endfunction
  task automatic write_sel(input logic [1:0] code);
    presc_sel_in = code;
    presc_wr_in = 1'b1;
    tick(1);
    presc_wr_in = 1'b0;
    tick(1);
  endtask
  task automatic do_reset(output int n);
    nrst_in = 1'b0;
    tick(8);
    chk("reset outputs", {pt, bc, als, run, win, sel}, 16'h0004);
    chk("reset count", cnt, 16'h0000);
    nrst_in = 1'b1;
    for (n = 0; run !== 1'b1 && n < 200; n++)
      tick(1);
  endtask
  always @(posedge sys_clk_in)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      mismatches++;
      end_of_test();
    end
  end
  // ==========================================
  // Main sequence
  initial
  begin
    int n, t_pt, t_bc;
    logic prev;
    logic [15:0] c0;
    logic [1:0] code;
    logic [7:0] p0, r0, w0;
    void'($urandom(48356));
    do_reset(n);
    chk("startup wait", 16'(n >= 28 && n <= 60), 16'h1);
    prev = pt;
    t_pt = 0;
    t_bc = 0;
    for (int i = 0; i < 8; i++)
    begin
      tick(1);
      chk("bus clock lag", bc, prev);
      chk("strobe overlap", als & pt, 16'h0);
      t_pt += pt;
      t_bc += als;
      prev = pt;
    end
    chk("phase two duty", 16'(t_pt), 16'h4);
    chk("strobe count", 16'(t_bc), 16'h2);
    code = 2'($urandom_range(3, 1));
    write_sel(code);
    chk("early write", sel, code);
    write_sel(code - 2'h1);
    chk("second write", sel, code);
    c0 = cnt;
    tick(256);
    chk("chosen rate", cnt - c0, rate(code, 64));
    for (n = 0; win !== 1'b0 && n < 400; n++)
      tick(1);
    chk("window closes", 16'(n < 400), 16'h1);
    do_reset(n);
    for (n = 0; win !== 1'b0 && n < 400; n++)
      tick(1);
    write_sel(2'h3);
    chk("late write", sel, 16'h0);
    c0 = cnt;
    tick(64);
    chk("default rate", cnt - c0, 16'h0010);
    test_mode_in = 1'b1;
    for (int k = 0; k < 4; k++)
    begin
      write_sel(2'(k));
      chk("test write", sel, 16'(k));
      tick(512 + 256 * $urandom_range(1, 0));
      c0 = cnt;
      p0 = np;
      r0 = nr;
      w0 = nw;
      tick(2048);
      chk("count rate", cnt - c0, rate(2'(k), 512));
      chk("pulse tap", 8'(np - p0), 16'h8);
      chk("periodic tap", 8'(nr - r0), 16'h2);
      chk("watchdog tap", 8'(nw - w0), 16'h1);
    end
    baud_clear_in = 1'b1;
    tick(3);
    chk("baud clear", baud, 16'h0);
    test_mode_in = 1'b0;
    c0 = 16'(baud);
    tick(64);
    chk("baud free run", 13'(baud - c0[12:0]), 16'h0010);
    baud_clear_in = 1'b0;
    stop_req_in = 1'b1;
    for (n = 0; run !== 1'b0 && n < 8; n++)
      tick(1);
    stop_req_in = 1'b0;
    tick(4);
    chk("stopped clocks", {run, pt, bc}, 16'h0);
    wake_in = 1'b1;
    tick(1);
    wake_in = 1'b0;
    t_pt = 999;
    t_bc = 999;
    for (n = 1; n <= 80; n++)
    begin
      tick(1);
      t_pt = (pt === 1'b1 && n < t_pt) ? n : t_pt;
      t_bc = (bc === 1'b1 && n < t_bc) ? n : t_bc;
    end
    chk("wake delay", 16'(t_pt >= 28 && t_pt < 999), 16'h1);
    chk("bus clock later", 16'(t_bc > t_pt && t_bc < 999), 16'h1);
    chk("running again", run, 16'h1);
    end_of_test();
  end
endmodule
